// File: rtl/data_space_consts.svh
// address map, pointer locations and access timing of the data space decoder
`ifndef DATA_SPACE_CONSTS_SVH
`define DATA_SPACE_CONSTS_SVH

`define REGS_LAST 16'h001f
`define STDIO_FIRST 16'h0020
`define STDIO_LAST 16'h005f
`define EXTIO_FIRST 16'h0060
`define EXTIO_LAST 16'h01ff
`define ISRAM_FIRST 16'h0200
`define ISRAM_LAST 16'h21ff
`define ISRAM_BYTES 8192
`define XSRAM_FIRST 16'h2200
`define XSRAM_LAST 16'hffff
`define SHORT_IO_OFFSET 16'h0020
`define PTR_X_LO 5'h1a
`define PTR_Y_LO 5'h1c
`define PTR_Z_LO 5'h1e
`define PC_STACK_BYTES 2'h3
`define SINGLE_BYTES 2'h1
`define LAST_PC_STROBE 4'h1

`endif

// File: rtl/data_space_pkg.sv
// types shared by the data space decoder and its strobe timer
package data_space_pkg;

  typedef enum logic [2:0] {
    MODE_DIRECT = 3'b000,
    MODE_DISP = 3'b001,
    MODE_IND = 3'b010,
    MODE_PREDEC = 3'b011,
    MODE_POSTINC = 3'b100,
    MODE_SHORT_IO = 3'b101
  } addr_mode_type;

  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } ptr_sel_type;

  typedef enum logic [2:0] {
    RGN_REG_FILE = 3'b000,
    RGN_STD_IO = 3'b001,
    RGN_EXT_IO = 3'b010,
    RGN_INT_SRAM = 3'b011,
    RGN_EXT_SRAM = 3'b100,
    RGN_UNMAPPED = 3'b101
  } region_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INT = 2'b01,
    ST_ADDR = 2'b10,
    ST_STROBE = 2'b11
  } fsm_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic pc_stack;
    addr_mode_type mode;
    ptr_sel_type ptr;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [23:0] wdata;
  } req_type;

  typedef struct packed {
    logic done;
    logic unmapped;
    logic [23:0] rdata;
  } resp_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic extended;
    logic [8:0] addr;
    logic [7:0] wdata;
  } io_req_type;

  typedef struct packed {
    logic port_override;
    logic [7:0] addr_hi;
    logic [7:0] ad_out;
    logic ad_oe;
    logic ale;
    logic ext_read_strobe_pin_n;
    logic ext_write_strobe_pin_n;
  } external_memory_interface_pins_type;

endpackage

// File: rtl/strobe_timer.sv
// counts the length of one external strobe
`timescale 1ns/100ps
module strobe_timer #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] len,
  output logic expire
);
  import data_space_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } timer_state_type;

  timer_state_type s_reg;
  timer_state_type s_next;

  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.cnt = len;
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // strobe ends on the cycle the count reaches one
  assign expire = (s_reg.cnt == WIDTH'(1));
endmodule

// File: rtl/data_space_decoder.sv
// data space decoder: region routing, pointers and external sram strobes
`timescale 1ns/100ps
`include "data_space_consts.svh"
module data_space_decoder #(
  parameter int ISRAM_DEPTH = `ISRAM_BYTES,
  parameter int ISRAM_AW = $clog2(ISRAM_DEPTH)
) (
  input wire logic clk_sys,
  input wire logic rst,
  input data_space_pkg::req_type req,
  output logic req_ready,
  output data_space_pkg::resp_type resp,
  output data_space_pkg::io_req_type io_req,
  input wire logic [7:0] io_rdata,
  input wire logic ext_sram_enable_bit,
  input wire logic [1:0] ext_wait_states,
  input wire logic [7:0] ext_ad_in,
  output data_space_pkg::external_memory_interface_pins_type external_memory_interface_pins
);
  import data_space_pkg::*;

  typedef struct packed {
    fsm_type fsm;
    logic write;
    logic multi;
    logic [15:0] addr;
    logic [1:0] idx;
    logic [23:0] wdata;
    logic [23:0] rdata;
    logic unmapped;
    logic wb_en;
    logic [4:0] wb_lo;
    logic [15:0] wb_val;
    logic done;
    // the bus answers our own strobes, so one capture stage keeps the
    // sample inside the address or strobe window; a second stage would read the idle bus
    logic [7:0] ad_in_q;
  } dec_state_type;

  dec_state_type s_reg;
  dec_state_type s_next;

  logic [7:0] regfile [32];
  logic [7:0] isram [ISRAM_DEPTH];

  logic [15:0] cur_addr;
  logic [1:0] last_idx;
  logic is_last;
  region_type cur_rgn;
  logic [7:0] cur_wbyte;
  logic [4:0] req_ptr_lo;
  logic [15:0] req_ptr;
  logic [15:0] eff_addr;
  logic [ISRAM_AW-1:0] isram_idx;
  logic timer_load;
  logic [3:0] timer_len;
  logic timer_expire;
  logic rf_wr;
  logic sram_wr;

  // region of one byte address; unmapped only while the interface is off

  function automatic region_type decode(input logic [15:0] a, input logic en);
    region_type r;
    if (a <= `REGS_LAST) begin
      r = RGN_REG_FILE;
    end else if (a <= `STDIO_LAST) begin
      r = RGN_STD_IO;
    end else if (a <= `EXTIO_LAST) begin
      r = RGN_EXT_IO;
    end else if (a <= 16'(`ISRAM_FIRST + ISRAM_DEPTH - 1)) begin
      r = RGN_INT_SRAM;
    end else if (en) begin
      r = RGN_EXT_SRAM;
    end else begin
      // no wrap into internal sram when the interface is off
      r = RGN_UNMAPPED;
    end
    return r;
  endfunction

  // pointer pairs live in the top six working registers, low byte first
  always_comb begin
    unique case (req.ptr)
      PTR_X: req_ptr_lo = `PTR_X_LO;
      PTR_Y: req_ptr_lo = `PTR_Y_LO;
      PTR_Z: req_ptr_lo = `PTR_Z_LO;
      default: req_ptr_lo = `PTR_Z_LO;
    endcase
  end
  assign req_ptr = {regfile[req_ptr_lo + 5'h01], regfile[req_ptr_lo]};

  always_comb begin
    unique case (req.mode)
      MODE_DIRECT: eff_addr = req.addr;
      MODE_DISP: eff_addr = req_ptr + {10'h000, req.disp};
      MODE_IND: eff_addr = req_ptr;
      MODE_PREDEC: eff_addr = req_ptr - 16'h0001;
      MODE_POSTINC: eff_addr = req_ptr;
      MODE_SHORT_IO: eff_addr = {10'h000, req.addr[5:0]} + `SHORT_IO_OFFSET;
      default: eff_addr = req.addr;
    endcase
  end


  // byte under way within a single or three-byte operation
  assign cur_addr = s_reg.addr + {14'h0000, s_reg.idx};
  assign last_idx = s_reg.multi ? (`PC_STACK_BYTES - 2'h1) : (`SINGLE_BYTES - 2'h1);
  assign is_last = (s_reg.idx == last_idx);
  assign cur_rgn = decode(cur_addr, ext_sram_enable_bit);
  assign cur_wbyte = s_reg.wdata[8*s_reg.idx +: 8];
  assign isram_idx = ISRAM_AW'(cur_addr - `ISRAM_FIRST);
  assign req_ready = (s_reg.fsm == ST_IDLE);


  // last byte of a stack op overlaps the pipeline, so it needs one strobe cycle
  always_comb begin
    if (s_reg.multi && is_last) begin
      timer_len = `LAST_PC_STROBE;
    end else begin
      timer_len = {2'b00, ext_wait_states} + 4'h1;
    end
  end


  // strobe length is loaded while the address is on the bus
  assign timer_load = (s_reg.fsm == ST_ADDR);


  strobe_timer #(
    .WIDTH(4)
  ) u_strobe_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(timer_load),
    .len(timer_len),
    .expire(timer_expire)
  );

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    // bus byte of the previous cycle, read at strobe end
    s_next.ad_in_q = ext_ad_in;

    unique case (s_reg.fsm)
      ST_IDLE: begin
        if (req.valid) begin
          s_next.write = req.write;
          s_next.multi = req.pc_stack;
          s_next.addr = eff_addr;
          s_next.idx = 2'h0;
          s_next.wdata = req.wdata;
          s_next.rdata = '0;
          s_next.unmapped = 1'b0;
          s_next.wb_lo = req_ptr_lo;
          s_next.wb_en = (req.mode == MODE_PREDEC) || (req.mode == MODE_POSTINC);
          s_next.wb_val = (req.mode == MODE_POSTINC) ? req_ptr + 16'h0001 : eff_addr;
          if (decode(eff_addr, ext_sram_enable_bit) == RGN_EXT_SRAM) begin
            s_next.fsm = ST_ADDR;
          end else begin
            s_next.fsm = ST_INT;
          end
        end
      end
      ST_INT: begin
        // one cycle per byte after the request cycle
        unique case (cur_rgn)
          RGN_REG_FILE: s_next.rdata[8*s_reg.idx +: 8] = regfile[cur_addr[4:0]];
          RGN_STD_IO, RGN_EXT_IO: s_next.rdata[8*s_reg.idx +: 8] = io_rdata;
          RGN_INT_SRAM: s_next.rdata[8*s_reg.idx +: 8] = isram[isram_idx];
          default: s_next.unmapped = 1'b1;
        endcase
        if (is_last) begin
          s_next.done = 1'b1;
          s_next.fsm = ST_IDLE;
        end else begin
          s_next.idx = s_reg.idx + 2'h1;
        end
      end
      ST_ADDR: begin
        // address phase lasts one cycle, ale high
        s_next.fsm = ST_STROBE;
      end

      ST_STROBE: begin
        if (timer_expire) begin
          // holds the bus as seen in the previous strobe or address cycle
          s_next.rdata[8*s_reg.idx +: 8] = s_reg.ad_in_q;
          if (is_last) begin
            s_next.done = 1'b1;
            s_next.fsm = ST_IDLE;
          end else begin
            s_next.idx = s_reg.idx + 2'h1;
            s_next.fsm = ST_ADDR;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end


  // internal stores land at the end of their single INT cycle
  assign rf_wr = (s_reg.fsm == ST_INT) && s_reg.write && (cur_rgn == RGN_REG_FILE);
  assign sram_wr = (s_reg.fsm == ST_INT) && s_reg.write && (cur_rgn == RGN_INT_SRAM);


  // pointer write-back wins over a data store into the same pointer byte
  always_ff @(posedge clk_sys) begin
    if (rf_wr) begin
      regfile[cur_addr[4:0]] <= cur_wbyte;
    end
    if (s_next.done && s_reg.wb_en) begin
      regfile[s_reg.wb_lo] <= s_reg.wb_val[7:0];
      regfile[s_reg.wb_lo + 5'h01] <= s_reg.wb_val[15:8];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sram_wr) begin
      isram[isram_idx] <= cur_wbyte;
    end
  end


  // peripheral request only during the internal byte cycle
  always_comb begin
    io_req = '0;
    if (s_reg.fsm == ST_INT) begin
      io_req.valid = (cur_rgn == RGN_STD_IO) || (cur_rgn == RGN_EXT_IO);
      io_req.extended = (cur_rgn == RGN_EXT_IO);
      io_req.write = s_reg.write;
      io_req.addr = cur_addr[8:0];
      io_req.wdata = cur_wbyte;
    end
  end


  // response fields come straight from state flops
  assign resp.done = s_reg.done;
  assign resp.unmapped = s_reg.unmapped;
  assign resp.rdata = s_reg.rdata;


  // with the interface on, internal accesses show address and latch enable, never strobes
  always_comb begin
    external_memory_interface_pins = '0;
    external_memory_interface_pins.ext_read_strobe_pin_n = 1'b1;
    external_memory_interface_pins.ext_write_strobe_pin_n = 1'b1;
    external_memory_interface_pins.port_override = ext_sram_enable_bit;
    if (ext_sram_enable_bit && (s_reg.fsm != ST_IDLE)) begin
      external_memory_interface_pins.addr_hi = cur_addr[15:8];
      external_memory_interface_pins.ad_out = cur_addr[7:0];
      external_memory_interface_pins.ad_oe = 1'b1;
      external_memory_interface_pins.ale = (s_reg.fsm == ST_ADDR) || (s_reg.fsm == ST_INT);
    end
    if (s_reg.fsm == ST_STROBE) begin
      external_memory_interface_pins.ad_out = s_reg.write ? cur_wbyte : 8'h00;
      external_memory_interface_pins.ad_oe = s_reg.write;
      external_memory_interface_pins.ext_read_strobe_pin_n = s_reg.write;
      external_memory_interface_pins.ext_write_strobe_pin_n = !s_reg.write;
    end
  end
endmodule

// File: tb/data_space_checker.sv
// concurrent checks on the ports of the data space decoder
`timescale 1ns/100ps
module data_space_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input data_space_pkg::req_type req,
  input wire logic req_ready,
  input data_space_pkg::resp_type resp,
  input data_space_pkg::io_req_type io_req,
  input wire logic ext_sram_enable_bit,
  input wire logic [1:0] ext_wait_states,
  input data_space_pkg::external_memory_interface_pins_type external_memory_interface_pins
);
  import data_space_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic take, dir, strb;
  assign take = req.valid && req_ready;
  assign dir = take && req.mode == MODE_DIRECT && !req.pc_stack;
  assign strb = external_memory_interface_pins.ext_read_strobe_pin_n && external_memory_interface_pins.ext_write_strobe_pin_n;
  a_int_strobe_idle: assert property (dir && req.addr < 16'h2200 |-> strb [*3])
    else $error("strobe on internal access");
  a_int_done_time: assert property (
    dir && req.addr inside {[16'h0200:16'h21ff]} |-> ##[1:2] resp.done)
    else $error("internal sram access late");
  a_ext_wr_walk: assert property (
    dir && req.write && req.addr >= 16'h2200 && ext_sram_enable_bit && ext_wait_states == 2'h0
    |-> ##1 external_memory_interface_pins.ale ##1 !external_memory_interface_pins.ext_write_strobe_pin_n
    ##1 (resp.done && external_memory_interface_pins.ext_write_strobe_pin_n))
    else $error("external write sequence wrong");
  a_off_no_strobe: assert property (!ext_sram_enable_bit |-> strb)
    else $error("strobe while disabled");
  a_override_en: assert property (external_memory_interface_pins.port_override == ext_sram_enable_bit)
    else $error("pin override wrong");
  a_short_io_map: assert property (take && req.mode == MODE_SHORT_IO |=>
    io_req.valid && !io_req.extended && io_req.addr == {3'h0, $past(req.addr[5:0])} + 9'h020)
    else $error("short io address wrong");
  a_io_region: assert property (dir && req.addr inside {[16'h0020:16'h01ff]} |=>
    io_req.valid && io_req.extended == ($past(req.addr) >= 16'h0060))
    else $error("io routing wrong");
  a_mem_no_io: assert property (
    dir && (req.addr < 16'h0020 || req.addr >= 16'h0200) |=> !io_req.valid)
    else $error("memory access reached io");
  a_done_pulse: assert property (resp.done |=> !resp.done)
    else $error("done longer than one cycle");
  c_ext_wr: cover property (dir && req.write && req.addr >= 16'h2200 && ext_sram_enable_bit);
  c_short_io: cover property (take && req.mode == MODE_SHORT_IO);
  c_stack: cover property (take && req.pc_stack ##[1:20] resp.done);
endmodule

// File: tb/ext_sram_model.sv
// external sram with its address latch on the multiplexed bus
`timescale 1ns/100ps
module ext_sram_model (
  input wire logic clk_sys,
  input data_space_pkg::external_memory_interface_pins_type external_memory_interface_pins,
  output logic [7:0] ext_ad_in
);
  import data_space_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] lat_lo;
  logic [7:0] last = 8'h00;
  logic [15:0] a;
  logic sel;
  assign a = {external_memory_interface_pins.addr_hi, external_memory_interface_pins.ale ? external_memory_interface_pins.ad_out : lat_lo};
  // data shown from ale on, as the decoder's one-flop sampling needs
  assign sel = external_memory_interface_pins.port_override && (external_memory_interface_pins.ale || !external_memory_interface_pins.ext_read_strobe_pin_n);
  // no keeper: a released bus shows the inverse of its last value
  assign ext_ad_in = sel ? mem[a] : ~last;
  always @(posedge clk_sys) begin
    if (external_memory_interface_pins.ale)
      lat_lo <= external_memory_interface_pins.ad_out;
    if (sel)
      last <= mem[a];
    if (external_memory_interface_pins.port_override && !external_memory_interface_pins.ext_write_strobe_pin_n)
      mem[a] <= external_memory_interface_pins.ad_out;
  end
endmodule

// File: tb/tb.sv
// testbench of the data space decoder
`timescale 1ns/100ps
module tb;
  import data_space_pkg::*;
  logic clk_sys = 0;
  logic rst = 1;
  logic en = 0;
  logic [1:0] ws = 0;
  logic [7:0] io_rdata = 8'h5a;
  logic [7:0] ad_in;
  req_type req = '0;
  logic req_ready;
  resp_type resp;
  io_req_type io_req;
  external_memory_interface_pins_type pins;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int li, lp, l;
  always #5 clk_sys = ~clk_sys;
  data_space_decoder uut (.clk_sys(clk_sys), .rst(rst), .req(req), .req_ready(req_ready),
    .resp(resp), .io_req(io_req), .io_rdata(io_rdata), .ext_sram_enable_bit(en),
    .ext_wait_states(ws), .ext_ad_in(ad_in), .external_memory_interface_pins(pins));
  ext_sram_model sram (.clk_sys(clk_sys), .external_memory_interface_pins(pins), .ext_ad_in(ad_in));
  task automatic chk(input string s, input logic [23:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // l counts cycles from the taking edge to the done pulse
  task automatic acc(input logic w, pc, input addr_mode_type m, input ptr_sel_type p,
      input logic [5:0] d, input logic [15:0] a, input logic [23:0] wd);
    req = '{1'b1, w, pc, m, p, d, a, wd};
    @(posedge clk_sys);
    #1 req.valid = 0;
    l = 1;
    while (resp.done !== 1'b1 && l < 40) begin
      @(posedge clk_sys);
      #1 l++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [23:0] wd);
    acc(1, 0, MODE_DIRECT, PTR_X, 0, a, wd);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    acc(0, 0, MODE_DIRECT, PTR_X, 0, a, 0);
    chk("rdata", {16'h0, e}, {16'h0, resp.rdata[7:0]});
  endtask
  task automatic t_map;
    wr(16'h0200, 24'h11);
    li = l;
    chk("int lat", 24'h1, 24'(li <= 2));
    wr(16'h21ff, 24'h22);
    wr(16'h001f, 24'h33);
    rd(16'h0200, 8'h11);
    rd(16'h21ff, 8'h22);
    rd(16'h001f, 8'h33);
    rd(16'h0020, 8'h5a);
    rd(16'h01ff, 8'h5a);
    acc(0, 0, MODE_SHORT_IO, PTR_X, 0, 16'h003f, 0);
    chk("short io", 24'h5a, {16'h0, resp.rdata[7:0]});
    $display("test map done");
  endtask
  task automatic t_ext;
    en = 1;
    for (int i = 0; i < 4; i++) begin
      ws = 2'(i);
      wr(16'h2200 + 16'(i), 24'(8'ha0 + i));
      chk("ext lat", 24'(li + 1 + i), 24'(l));
      rd(16'h2200 + 16'(i), 8'(8'ha0 + i));
    end
    wr(16'hffff, 24'h5c);
    rd(16'hffff, 8'h5c);
    $display("test ext done");
  endtask
  task automatic t_stack;
    ws = 0;
    acc(1, 1, MODE_DIRECT, PTR_X, 0, 16'h0400, 24'h332211);
    lp = l;
    for (int i = 0; i < 4; i++) begin
      ws = 2'(i);
      acc(1, 1, MODE_DIRECT, PTR_X, 0, 16'h8000 + 16'(i * 4), 24'h665544);
      chk("stack lat", 24'(lp + 3 + 2 * i), 24'(l));
      acc(0, 1, MODE_DIRECT, PTR_X, 0, 16'h8000 + 16'(i * 4), 0);
      chk("stack data", 24'h665544, resp.rdata);
    end
    $display("test stack done");
  endtask
  task automatic t_off;
    en = 0;
    wr(16'h3000, 24'h77);
    rd(16'h3000, 8'h00);
    chk("unmapped", 24'h1, {23'h0, resp.unmapped});
    wr(16'h2200, 24'h99);
    rd(16'h0200, 8'h11);
    $display("test off done");
  endtask
  task automatic t_ptr;
    wr(16'h001a, 24'h00);
    wr(16'h001b, 24'h03);
    acc(1, 0, MODE_POSTINC, PTR_X, 0, 0, 24'h44);
    rd(16'h0300, 8'h44);
    rd(16'h001a, 8'h01);
    acc(1, 0, MODE_PREDEC, PTR_X, 0, 0, 24'h55);
    rd(16'h0300, 8'h55);
    rd(16'h001a, 8'h00);
    wr(16'h033f, 24'h66);
    wr(16'h001e, 24'h00);
    wr(16'h001f, 24'h03);
    acc(0, 0, MODE_DISP, PTR_Z, 6'h3f, 0, 0);
    chk("disp", 24'h66, {16'h0, resp.rdata[7:0]});
    $display("test ptr done");
  endtask
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 rst = 0;
    t_map;
    t_ext;
    t_stack;
    t_off;
    t_ptr;
    wrap_up;
  end
  // a hang costs a mismatch
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up;
    end
  end
endmodule
bind data_space_decoder data_space_checker chk_i (.clk_sys(clk_sys), .rst(rst), .req(req),
  .req_ready(req_ready), .resp(resp), .io_req(io_req),
  .ext_sram_enable_bit(ext_sram_enable_bit), .ext_wait_states(ext_wait_states),
  .external_memory_interface_pins(external_memory_interface_pins));
